/* flash_por_defs.svh */
// Timing and mode constants for the serial flash power-on sequencer
`ifndef FLASH_POR_DEFS_SVH
`define FLASH_POR_DEFS_SVH

`define CLK_HZ               40000000
// Least select delay after supply, in microseconds
`define SEL_DELAY_US         70
// Scale the clock down first so the product stays inside 32 bits
`define SEL_DELAY_CYC        (`SEL_DELAY_US * (`CLK_HZ / 1000000))
// Longest write delay after power-up, in milliseconds
`define WR_DELAY_MS          20
`define WR_DELAY_CYC         ((`WR_DELAY_MS * `CLK_HZ) / 1000)
`define CNT_W                20
`define MODE_DEFAULT         1'b1
`define MODE_ZERO            1'b0
`define MODE_THREE           1'b1

`endif

/* flash_por_pkg.sv */
// Types for the serial flash power-on sequencer
`default_nettype none
package flash_por_pkg;
  typedef enum logic [1:0] {
    ST_RESET,
    ST_WAIT,
    ST_STANDBY,
    ST_ACTIVE
  } por_state_t;
endpackage : flash_por_pkg
`default_nettype wire

/* sync2.sv */
// Two-flop synchroniser for one pin input
`default_nettype none
module sync2 (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic rst_val,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // First flop is read only by the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= rst_val;
      dout   <= rst_val;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : sync2
`default_nettype wire

/* flash_por_seq.sv */
// Power-on and select sequencing of a serial flash interface
`default_nettype none
`include "flash_por_defs.svh"
module flash_por_seq #(
  parameter logic [`CNT_W-1:0] WR_DELAY = `CNT_W'(`WR_DELAY_CYC)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Power-on reset from supply monitor, active high
  input  wire logic por_active,
  // Serial pins from host
  input  wire logic sel_n,
  input  wire logic sck,
  input  wire logic si,
  // Serial output from the core when it wants to drive
  input  wire logic core_so,
  input  wire logic core_so_drive,
  // Serial output pin
  output logic      so_o,
  output logic      so_oe,
  // Status and gated serial clock and data toward the core
  output logic      mode3,
  output logic      cmd_start,
  output logic      cmd_active,
  output logic      standby,
  output logic      write_ok,
  output logic      read_ok,
  output logic      sck_o,
  output logic      si_o
);
  localparam logic [`CNT_W-1:0] SEL_DELAY = `CNT_W'(`SEL_DELAY_CYC);

  logic sel_n_s;
  logic sck_s;
  logic si_s;
  logic por_s;
  logic sel_n_p_q;
  logic [`CNT_W-1:0] wr_cnt_q;
  logic [`CNT_W-1:0] rd_cnt_q;
  flash_por_pkg::por_state_t state_q;
  flash_por_pkg::por_state_t state_d;

  // Pin inputs cross into clk domain
  sync2 u_sel (.clk(clk), .srst(srst), .rst_val(1'b1),
               .din(sel_n), .dout(sel_n_s));
  sync2 u_sck (.clk(clk), .srst(srst), .rst_val(1'b0),
               .din(sck), .dout(sck_s));
  sync2 u_si  (.clk(clk), .srst(srst), .rst_val(1'b0),
               .din(si), .dout(si_s));
  sync2 u_por (.clk(clk), .srst(srst), .rst_val(1'b0),
               .din(por_active), .dout(por_s));

  // Select edge decode on synchronised copy only
  wire in_reset = srst | por_s;
  wire sel_fall = sel_n_p_q & ~sel_n_s;
  wire sel_rise = ~sel_n_p_q & sel_n_s;
  wire delay_done = (rd_cnt_q == SEL_DELAY);
  wire accept = sel_fall & (state_q != flash_por_pkg::ST_RESET);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      flash_por_pkg::ST_RESET: begin
        state_d = flash_por_pkg::ST_WAIT;
      end
      flash_por_pkg::ST_WAIT: begin
        if (delay_done) begin
          state_d = flash_por_pkg::ST_STANDBY;
        end
      end
      flash_por_pkg::ST_STANDBY: begin
        if (sel_fall) begin
          state_d = flash_por_pkg::ST_ACTIVE;
        end
      end
      flash_por_pkg::ST_ACTIVE: begin
        if (sel_rise) begin
          state_d = flash_por_pkg::ST_STANDBY;
        end
      end
      default: state_d = flash_por_pkg::ST_RESET;
    endcase
  end

  // State and delay counters; power-on reset restarts all of it
  always_ff @(posedge clk) begin
    if (in_reset) begin
      state_q   <= flash_por_pkg::ST_RESET;
      sel_n_p_q <= 1'b1;
      rd_cnt_q  <= '0;
      wr_cnt_q  <= '0;
    end else begin
      state_q   <= state_d;
      sel_n_p_q <= sel_n_s;
      if (!delay_done) begin
        rd_cnt_q <= rd_cnt_q + `CNT_W'(1);
      end
      if (wr_cnt_q != WR_DELAY) begin
        wr_cnt_q <= wr_cnt_q + `CNT_W'(1);
      end
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk) begin
    if (in_reset) begin
      mode3      <= `MODE_DEFAULT;
      so_o       <= 1'b0;
      so_oe      <= 1'b0;
      cmd_start  <= 1'b0;
      cmd_active <= 1'b0;
      standby    <= 1'b0;
      write_ok   <= 1'b0;
      read_ok    <= 1'b0;
      sck_o      <= 1'b0;
      si_o       <= 1'b0;
    end else begin
      if (accept) begin
        mode3 <= sck_s ? `MODE_THREE : `MODE_ZERO;
      end
      cmd_start  <= accept;
      cmd_active <= (state_d == flash_por_pkg::ST_ACTIVE);
      standby    <= (state_d == flash_por_pkg::ST_STANDBY);
      read_ok    <= delay_done;
      write_ok   <= (wr_cnt_q == WR_DELAY);
      // Deselected: clock, data and output enable all quiet; so_o follows core_so except in reset, where it is 0
      sck_o      <= (state_d == flash_por_pkg::ST_ACTIVE) & sck_s;
      si_o       <= (state_d == flash_por_pkg::ST_ACTIVE) & si_s;
      so_oe      <= (state_d == flash_por_pkg::ST_ACTIVE)
                    & core_so_drive;
      so_o       <= core_so;
    end
  end

  // Output enable only inside a selected operation
  property p_so_quiet;
    @(posedge clk) disable iff (srst)
      (state_q != flash_por_pkg::ST_ACTIVE) |-> !so_oe;
  endproperty
  a_so_quiet: assert property (p_so_quiet)
    else $error("output driven outside an operation");

  sequence s_fall;
    sel_fall && !in_reset && state_q != flash_por_pkg::ST_RESET;
  endsequence
  property p_mode_pick;
    @(posedge clk) disable iff (srst)
      s_fall |=> (mode3 == $past(sck_s));
  endproperty
  a_mode_pick: assert property (p_mode_pick)
    else $error("mode not taken from idle clock");

  property p_start_pulse;
    @(posedge clk) disable iff (srst)
      s_fall |=> cmd_start ##1 !cmd_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse wrong");

  property p_por_block;
    @(posedge clk) disable iff (srst)
      por_s |=> !cmd_start && !write_ok && !read_ok;
  endproperty
  a_por_block: assert property (p_por_block)
    else $error("activity during power-on reset");

  property p_reset_mode;
    @(posedge clk) in_reset |=> mode3;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode after reset not 3");

  property p_write_gate;
    @(posedge clk) disable iff (srst)
      write_ok |-> $past(wr_cnt_q) == WR_DELAY;
  endproperty
  a_write_gate: assert property (p_write_gate)
    else $error("write allowed early");

  property p_read_gate;
    @(posedge clk) disable iff (srst)
      read_ok |-> $past(rd_cnt_q) == SEL_DELAY;
  endproperty
  a_read_gate: assert property (p_read_gate)
    else $error("read allowed early");

  property p_standby;
    @(posedge clk) disable iff (srst)
      (state_q == flash_por_pkg::ST_WAIT && delay_done && !in_reset)
        |=> standby;
  endproperty
  a_standby: assert property (p_standby)
    else $error("no standby after power-up");

  property p_idle_in;
    @(posedge clk) disable iff (srst)
      (state_q != flash_por_pkg::ST_ACTIVE && state_d
        != flash_por_pkg::ST_ACTIVE) |=> !sck_o && !si_o;
  endproperty
  a_idle_in: assert property (p_idle_in)
    else $error("input passed while deselected");
endmodule : flash_por_seq
`default_nettype wire

/* host_ctl.sv */
// Behavioural host that frames select, shift clock and serial input
`default_nettype none
module host_ctl (
  // Clock
  input  wire logic clk,
  // Bench controls
  input  wire logic frame,
  input  wire logic idle_hi,
  // Serial pins toward the device
  output logic      sel_n,
  output logic      sck,
  output logic      si
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;

  initial begin
    sel_n = 1'b1;
    sck   = 1'b1;
    si    = 1'b0;
    cnt_q = 4'h0;
  end

  // Clock stands at idle outside frames; input keeps toggling there
  // so a device that wrongly listens would see junk, not a quiet 0
  always @(negedge clk) begin
    if (!frame) begin
      sel_n <= 1'b1;
      sck   <= idle_hi;
      si    <= ~si;
      cnt_q <= 4'h0;
    end else begin
      sel_n <= 1'b0;
      cnt_q <= cnt_q + 4'h1;
      si    <= cnt_q[0];
      if (cnt_q >= 4'h4) begin
        sck <= ~sck;
      end
    end
  end
endmodule : host_ctl
`default_nettype wire

/* test_flash_por_seq.sv */
// Self-checking bench for the power-on and select sequencer
`default_nettype none
module test_flash_por_seq;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, por_active, frame, idle_hi, core_so, core_so_drive;
  logic sel_n, sck, si, so_o, so_oe, mode3, cmd_start, cmd_active;
  logic standby, write_ok, read_ok, sck_o, si_o;
  int   n_fail, num_checks;

  host_ctl host (.clk(clk), .frame(frame), .idle_hi(idle_hi),
    .sel_n(sel_n), .sck(sck), .si(si));
  flash_por_seq #(.WR_DELAY(20'h32)) dut (.clk(clk), .srst(srst),
    .por_active(por_active), .sel_n(sel_n), .sck(sck), .si(si),
    .core_so(core_so), .core_so_drive(core_so_drive), .so_o(so_o),
    .so_oe(so_oe), .mode3(mode3), .cmd_start(cmd_start),
    .cmd_active(cmd_active), .standby(standby), .write_ok(write_ok),
    .read_ok(read_ok), .sck_o(sck_o), .si_o(si_o));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Frame with a chosen idle clock; expect one start pulse or none
  task automatic do_frame(input logic idle, input logic exp_m,
                          input logic exp_go);
    bit seen;
    logic sck_seen;
    logic si_seen;
    seen = 0;
    sck_seen = 1'b0;
    si_seen = 1'b0;
    @(negedge clk) idle_hi = idle;
    repeat (4) @(negedge clk);
    frame <= 1'b1;
    for (int i = 0; i < 16 && !seen; i++) begin
      @(posedge clk) #1;
      if (cmd_start === 1'b1) seen = 1;
    end
    chk("start", exp_go, logic'(seen));
    chk("mode3", exp_m, mode3);
    if (exp_go) begin
      @(posedge clk) #1 chk("pulse_end", 1'b0, cmd_start);
      chk("active", 1'b1, cmd_active);
      @(negedge clk) core_so = 1'b1;
      // Selected: clock and data must reach the core
      for (int i = 0; i < 6; i++) begin
        @(negedge clk);
        sck_seen = sck_seen | sck_o;
        si_seen = si_seen | si_o;
      end
      chk("sck_pass", 1'b1, sck_seen);
      chk("si_pass", 1'b1, si_seen);
      chk("oe_on", 1'b1, so_oe);
      chk("so", 1'b1, so_o);
    end
    @(negedge clk) frame <= 1'b0;
    repeat (6) @(negedge clk);
    chk("oe_off", 1'b0, so_oe);
    chk("sck_gate", 1'b0, sck_o);
    chk("si_gate", 1'b0, si_o);
    core_so = 1'b0;
  endtask : do_frame

  // Cut a hang short well past the expected run length
  initial begin
    #(9000 * 25);
    n_fail++;
    close_out();
  end

  initial begin
    srst = 1'b1;
    por_active = 1'b0;
    frame = 1'b0;
    idle_hi = 1'b1;
    core_so = 1'b0;
    core_so_drive = 1'b1;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(negedge clk);
    chk("rst_mode3", 1'b1, mode3);
    chk("rst_oe", 1'b0, so_oe);
    srst = 1'b0;
    repeat (10) @(negedge clk);
    chk("wr_early", 1'b0, write_ok);
    chk("idle_oe", 1'b0, so_oe);
    chk("idle_si", 1'b0, si_o);
    repeat (50) @(negedge clk);
    chk("wr_late", 1'b1, write_ok);
    repeat (2720) @(negedge clk);
    chk("rd_early", 1'b0, read_ok);
    repeat (25) @(negedge clk);
    chk("rd_late", 1'b1, read_ok);
    chk("standby", 1'b1, standby);
    do_frame(1'b0, 1'b0, 1'b1);
    do_frame(1'b1, 1'b1, 1'b1);
    do_frame(1'b0, 1'b0, 1'b1);
    @(negedge clk) por_active = 1'b1;
    repeat (4) @(negedge clk);
    chk("por_mode3", 1'b1, mode3);
    do_frame(1'b0, 1'b1, 1'b0);
    por_active = 1'b0;
    // Host stays deselected until the select delay has run again
    repeat (2790) @(negedge clk);
    chk("rd_por_early", 1'b0, read_ok);
    repeat (20) @(negedge clk);
    chk("rd_por", 1'b1, read_ok);
    chk("standby_por", 1'b1, standby);
    do_frame(1'b0, 1'b0, 1'b1);
    srst = 1'b1;
    @(negedge clk) srst = 1'b0;
    @(posedge clk) #1 chk("srst_mode3", 1'b1, mode3);
    close_out();
  end
endmodule : test_flash_por_seq
`default_nettype wire
